/* hdl/dcdc_pkg.sv */
package dcdc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] SFR_PAGE_DCDC = 8'h00;
   localparam logic [7:0] ADDR_DCDC_CONFIG = 8'h96;
   localparam logic [7:0] ADDR_DCDC_CONTROL = 8'h97;
   localparam logic [7:0] RESET_DCDC_CONFIG = 8'h00;
   localparam logic [7:0] RESET_DCDC_CONTROL = 8'h21;
   // top bit of the config register is not stored
   localparam logic [7:0] MASK_DCDC_CONFIG = 8'h7f;
   localparam logic [7:0] MASK_DCDC_CONTROL = 8'hff;

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int MIN_PULSE_WIDTH_LSB = 6;
   localparam int SWITCH_SIZE_SELECT_BIT = 5;
   localparam int ADC_SYNC_BIT = 3;
   localparam int OUTPUT_VOLTAGE_SELECT_LSB = 0;

   // ------------------------------------------------------------
   // config fields
   // ------------------------------------------------------------
   localparam int CLOCK_DIVIDER_LSB = 5;
   localparam int ADC_SAR_CLOCK_INVERT_BIT = 4;
   localparam int CONVERTER_CLOCK_INVERT_BIT = 3;
   localparam int PEAK_CURRENT_LIMIT_BIT = 2;
   localparam int SLEEP_OUTPUT_CONNECTION_BIT = 1;
   localparam int CONVERTER_CLOCK_SOURCE_BIT = 0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int MIN_PW_SHORT_NS = 20;
   localparam int MIN_PW_MID_NS = 40;
   localparam int MIN_PW_LONG_NS = 80;
   localparam int LOCAL_OSC_KHZ = 2400;
   // least times round up, never below one cycle
   localparam int MIN_PW_SHORT_CYC = (MIN_PW_SHORT_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MIN_PW_MID_CYC = (MIN_PW_MID_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int MIN_PW_LONG_CYC = (MIN_PW_LONG_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int PULSE_CNT_W = 4;

   typedef enum logic [1:0] {
      MIN_PW_NONE,
      MIN_PW_SHORT,
      MIN_PW_MID,
      MIN_PW_LONG
   } min_pulse_width_e;

   typedef enum logic [1:0] {
      CLK_DIV_1,
      CLK_DIV_2,
      CLK_DIV_4,
      CLK_DIV_8
   } clock_divider_e;

   // regulation target in millivolts per select code
   localparam int TARGET_MV_W = 12;
   typedef logic [TARGET_MV_W-1:0] target_mv_t;
   localparam target_mv_t TARGET_MV [8] = '{
      12'd1800, 12'd1900, 12'd2000, 12'd2100,
      12'd2400, 12'd2700, 12'd3000, 12'd3300
   };

endpackage

/* hdl/dcdc_clk_if.sv */
`timescale 1ns/100ps
`default_nettype none

// converter clock as seen by the logic of the system clock domain
interface dcdc_clk_if;
   logic tick;
   logic phase;
   logic period_end;

   modport source (
      output tick,
      output phase,
      output period_end
   );

   modport sink (
      input tick,
      input phase,
      input period_end
   );
endinterface

`default_nettype wire

/* hdl/dcdc_clock_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module dcdc_clock_gen
   import dcdc_pkg::*;
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic source_sys_in,
   input wire logic [1:0] divider_in,
   input wire logic invert_in,
   input wire logic local_osc_in,
   dcdc_clk_if.source conv
);
   import dcdc_pkg::*;

   logic osc_meta_r;
   logic osc_sync_r;
   logic osc_prev_r;
   logic src_r;
   logic [1:0] div_r;
   logic inv_r;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic [2:0] last_cnt;
   logic [2:0] half_cnt;
   logic osc_rise;
   logic sys_wrap;
   logic boundary;
   logic sys_phase;

   // ------------------------------------------------------------
   // local oscillator synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         osc_meta_r <= 1'b0;
         osc_sync_r <= 1'b0;
         osc_prev_r <= 1'b0;
      end else begin
         osc_meta_r <= local_osc_in;
         osc_sync_r <= osc_meta_r;
         osc_prev_r <= osc_sync_r;
      end
   end

   assign osc_rise = osc_sync_r & ~osc_prev_r;
   assign last_cnt = 3'((1 << div_r) - 1);
   assign half_cnt = 3'((1 << div_r) >> 1);
   assign sys_wrap = (cnt_r == last_cnt);
   // divider ignored on the local oscillator
   assign boundary = src_r ? sys_wrap : osc_rise;
   assign cnt_nxt = sys_wrap ? 3'h0 : 3'(cnt_r + 3'h1);
   // divide by 1 holds high; others high in the first half
   assign sys_phase = (div_r == CLK_DIV_1) ? 1'b1 : (cnt_r < half_cnt);

   // ------------------------------------------------------------
   // divider; settings only take effect at a period boundary
   // so no runt converter clock pulse is produced while the system clock stays the source; the sar clock invert bit acts at once
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         src_r <= 1'b0;
         div_r <= 2'b00;
         inv_r <= 1'b0;
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= (src_r && !boundary) ? cnt_nxt : 3'h0;
         if (boundary) begin
            src_r <= source_sys_in;
            div_r <= divider_in;
            inv_r <= invert_in;
         end
      end
   end

   assign conv.period_end = boundary;
   assign conv.tick = src_r ? (cnt_r == 3'h0) : osc_rise;
   // inversion acts on the system clock path only
   assign conv.phase = src_r ? (sys_phase ^ inv_r) : osc_sync_r;
endmodule

`default_nettype wire

/* hdl/dcdc_adc_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module dcdc_adc_sync
   import dcdc_pkg::*;
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic sync_enable_in,
   input wire logic sar_invert_n_in,
   input wire logic switch_on_in,
   dcdc_clk_if.sink conv,
   output logic track_window_out,
   output logic sar_clock_out,
   output logic sar_tick_out
);
   import dcdc_pkg::*;

   logic track_r;
   logic sar_r;
   logic tick_r;
   logic sar_level;
   logic quiet;

   // quiet interval is the low phase with the switch off
   assign quiet = ~conv.phase & ~switch_on_in;
   // bit low means inverted sar clock
   assign sar_level = conv.phase ^ ~sar_invert_n_in;

   // ------------------------------------------------------------
   // outputs stay low when synchronisation is off
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         track_r <= 1'b0;
         sar_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         track_r <= sync_enable_in & quiet;
         sar_r <= sync_enable_in & sar_level;
         tick_r <= sync_enable_in & conv.tick;
      end
   end

   assign track_window_out = track_r;
   assign sar_clock_out = sar_r;
   assign sar_tick_out = tick_r;
endmodule

`default_nettype wire

/* hdl/dcdc_converter_control_regs.sv */
`timescale 1ns/100ps
`default_nettype none

module dcdc_converter_control_regs
   import dcdc_pkg::*;
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_page_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_hit_out,
   input wire logic two_cell_strap_in,
   input wire logic sleep_in,
   input wire logic local_osc_in,
   input wire logic above_target_in,
   output logic converter_enable_out,
   output logic switch_on_out,
   output logic small_switch_out,
   output logic high_current_limit_out,
   output logic [2:0] output_voltage_select_out,
   output logic [11:0] target_mv_out,
   output logic [1:0] min_pulse_width_out,
   output logic rail_to_battery_out,
   output logic rail_floating_out,
   output logic converter_clock_out,
   output logic adc_track_window_out,
   output logic adc_sar_clock_out,
   output logic adc_sar_tick_out
);
   import dcdc_pkg::*;

   logic [7:0] dcdc_control_r;
   logic [7:0] dcdc_config_r;
   logic strap_meta_r;
   logic strap_sync_r;
   logic strap_taken_r;
   logic two_cell_r;
   logic sleep_meta_r;
   logic sleep_sync_r;
   logic above_meta_r;
   logic above_sync_r;
   logic switch_r;
   logic [PULSE_CNT_W-1:0] pulse_cnt_r;
   logic [PULSE_CNT_W-1:0] pulse_cnt_nxt;
   logic [7:0] rdata_r;
   logic [2:0] output_voltage_select_r;
   logic [11:0] target_r;
   logic [1:0] min_pulse_width_r;
   logic small_r;
   logic peak_current_limit_r;
   logic to_bat_r;
   logic float_r;
   logic conv_clk_r;
   logic enable_r;

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   wire page_ok = (sfr_page_in == SFR_PAGE_DCDC);
   wire sel_control = page_ok & (sfr_addr_in == ADDR_DCDC_CONTROL);
   wire sel_config = page_ok & (sfr_addr_in == ADDR_DCDC_CONFIG);
   wire wr_control = sfr_wr_in & sel_control;
   wire wr_config = sfr_wr_in & sel_config;
   wire [7:0] read_mux = sel_control ? dcdc_control_r :
                         sel_config ? dcdc_config_r : 8'h00;

   // ------------------------------------------------------------
   // field views
   // ------------------------------------------------------------
   wire [1:0] min_pulse_width = dcdc_control_r[MIN_PULSE_WIDTH_LSB +: 2];
   wire switch_size_select = dcdc_control_r[SWITCH_SIZE_SELECT_BIT];
   wire adc_sync = dcdc_control_r[ADC_SYNC_BIT];
   wire [2:0] output_voltage_select = dcdc_control_r[OUTPUT_VOLTAGE_SELECT_LSB +: 3];
   wire [1:0] converter_clock_divider = dcdc_config_r[CLOCK_DIVIDER_LSB +: 2];
   wire adc_sar_clock_invert = dcdc_config_r[ADC_SAR_CLOCK_INVERT_BIT];
   wire converter_clock_invert = dcdc_config_r[CONVERTER_CLOCK_INVERT_BIT];
   wire peak_current_limit = dcdc_config_r[PEAK_CURRENT_LIMIT_BIT];
   wire sleep_output_connection = dcdc_config_r[SLEEP_OUTPUT_CONNECTION_BIT];
   wire converter_clock_source = dcdc_config_r[CONVERTER_CLOCK_SOURCE_BIT];

   // ------------------------------------------------------------
   // registers; reset values run the converter as is
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         dcdc_control_r <= RESET_DCDC_CONTROL;
         dcdc_config_r <= RESET_DCDC_CONFIG;
         rdata_r <= 8'h00;
      end else begin
         if (wr_control) begin
            dcdc_control_r <= sfr_wdata_in & MASK_DCDC_CONTROL;
         end
         if (wr_config) begin
            dcdc_config_r <= sfr_wdata_in & MASK_DCDC_CONFIG;
         end
         if (sfr_rd_in) begin
            rdata_r <= read_mux;
         end
      end
   end

   assign sfr_rdata_out = rdata_r;
   assign sfr_hit_out = sel_control | sel_config;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // strap pair runs through reset so the pin is settled at release
   always_ff @(posedge clock_in) begin
      strap_meta_r <= two_cell_strap_in;
      strap_sync_r <= strap_meta_r;
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sleep_meta_r <= 1'b0;
         sleep_sync_r <= 1'b0;
         above_meta_r <= 1'b0;
         above_sync_r <= 1'b0;
      end else begin
         sleep_meta_r <= sleep_in;
         sleep_sync_r <= sleep_meta_r;
         above_meta_r <= above_target_in;
         above_sync_r <= above_meta_r;
      end
   end

   // ------------------------------------------------------------
   // supply mode strap, caught once after reset release
   // ------------------------------------------------------------
   // converter held off until the strap has been caught
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_taken_r <= 1'b0;
         two_cell_r <= 1'b1;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         two_cell_r <= strap_sync_r;
      end
   end

   wire converter_run = strap_taken_r & ~two_cell_r & ~sleep_sync_r;
   wire one_cell_sleep = strap_taken_r & ~two_cell_r & sleep_sync_r;

   // ------------------------------------------------------------
   // converter clock and adc synchronisation
   // ------------------------------------------------------------
   dcdc_clk_if conv_clk ();

   // local_osc_in nominally LOCAL_OSC_KHZ
   dcdc_clock_gen u_clock_gen (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .source_sys_in(converter_clock_source),
      .divider_in(converter_clock_divider),
      .invert_in(converter_clock_invert),
      .local_osc_in(local_osc_in),
      .conv(conv_clk.source)
   );

   dcdc_adc_sync u_adc_sync (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .sync_enable_in(adc_sync),
      .sar_invert_n_in(adc_sar_clock_invert),
      .switch_on_in(switch_r),
      .conv(conv_clk.sink),
      .track_window_out(adc_track_window_out),
      .sar_clock_out(adc_sar_clock_out),
      .sar_tick_out(adc_sar_tick_out)
   );

   // ------------------------------------------------------------
   // minimum switch pulse
   // ------------------------------------------------------------
   wire [PULSE_CNT_W-1:0] min_cycles =
      (min_pulse_width == MIN_PW_SHORT) ? PULSE_CNT_W'(MIN_PW_SHORT_CYC) :
      (min_pulse_width == MIN_PW_MID) ? PULSE_CNT_W'(MIN_PW_MID_CYC) :
      (min_pulse_width == MIN_PW_LONG) ? PULSE_CNT_W'(MIN_PW_LONG_CYC) :
      PULSE_CNT_W'(0);
   wire min_met = (pulse_cnt_r >= min_cycles);
   // with no minimum the feedback may skip a pulse entirely
   wire start_pulse = converter_run & conv_clk.tick &
                      (~above_sync_r | (min_pulse_width != MIN_PW_NONE));
   wire end_pulse = ~converter_run | (min_met & (above_sync_r | ~conv_clk.phase));
   assign pulse_cnt_nxt = (pulse_cnt_r == {PULSE_CNT_W{1'b1}}) ? pulse_cnt_r :
                          PULSE_CNT_W'(pulse_cnt_r + 1'b1);

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         switch_r <= 1'b0;
         pulse_cnt_r <= '0;
      end else if (start_pulse && !switch_r) begin
         switch_r <= 1'b1;
         pulse_cnt_r <= PULSE_CNT_W'(1);
      end else if (switch_r && end_pulse) begin
         switch_r <= 1'b0;
         pulse_cnt_r <= '0;
      end else if (switch_r) begin
         pulse_cnt_r <= pulse_cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // analog stage settings
   // ------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         output_voltage_select_r <= 3'h0;
         target_r <= 12'h000;
         min_pulse_width_r <= 2'h0;
         small_r <= 1'b1;
         peak_current_limit_r <= 1'b0;
         to_bat_r <= 1'b0;
         float_r <= 1'b0;
         conv_clk_r <= 1'b0;
         enable_r <= 1'b0;
      end else begin
         output_voltage_select_r <= output_voltage_select;
         target_r <= TARGET_MV[output_voltage_select];
         min_pulse_width_r <= min_pulse_width;
         small_r <= switch_size_select;
         peak_current_limit_r <= peak_current_limit;
         to_bat_r <= one_cell_sleep & ~sleep_output_connection;
         float_r <= one_cell_sleep & sleep_output_connection;
         conv_clk_r <= converter_run & conv_clk.phase;
         enable_r <= converter_run;
      end
   end

   assign converter_enable_out = enable_r;
   assign switch_on_out = switch_r;
   assign small_switch_out = small_r;
   assign high_current_limit_out = peak_current_limit_r;
   assign output_voltage_select_out = output_voltage_select_r;
   assign target_mv_out = target_r;
   assign min_pulse_width_out = min_pulse_width_r;
   assign rail_to_battery_out = to_bat_r;
   assign rail_floating_out = float_r;
   assign converter_clock_out = conv_clk_r;
endmodule

`default_nettype wire

/* tb/dcdc_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module dcdc_far_side #(
   parameter int RISE_STEP = 3,
   parameter int FALL_STEP = 1
) (
   input wire logic clock_in,
   input wire logic switch_on_in,
   input wire logic adc_sar_tick_in,
   output logic local_osc_out,
   output logic above_target_out
);
   // sync needs the sar divider at zero
   localparam logic [4:0] adc_sar_clock_divider = 5'h00;
   int charge = 0;
   int sar_ticks = 0;
   // free running, no phase relation to the system clock
   always begin
      local_osc_out = 1'b0;
      #208.3;
      local_osc_out = 1'b1;
      #208.3;
   end
   always @(posedge clock_in) begin
      charge <= switch_on_in ? charge + RISE_STEP : (charge > FALL_STEP ? charge - FALL_STEP : 0);
      if (adc_sar_tick_in && adc_sar_clock_divider == 5'h00) begin
         sar_ticks <= sar_ticks + 1;
      end
   end
   assign above_target_out = charge > 12;
endmodule
`default_nettype wire

/* tb/dcdc_regs_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module dcdc_regs_checker
   import dcdc_pkg::*;
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_page_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic sfr_hit_out,
   input wire logic two_cell_strap_in,
   input wire logic sleep_in,
   input wire logic converter_enable_out,
   input wire logic switch_on_out,
   input wire logic [2:0] output_voltage_select_out,
   input wire logic [11:0] target_mv_out,
   input wire logic rail_to_battery_out,
   input wire logic rail_floating_out,
   input wire logic converter_clock_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   logic [1:0] settle_r;
   logic decode_hit;
   assign decode_hit = sfr_page_in == SFR_PAGE_DCDC &&
      (sfr_addr_in == ADDR_DCDC_CONFIG || sfr_addr_in == ADDR_DCDC_CONTROL);
   // settings outputs show reset values for one cycle after release
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         settle_r <= 2'h0;
      end else if (settle_r != 2'h3) begin
         settle_r <= settle_r + 2'h1;
      end
   end
   sequence reg_write_s;
      sfr_wr_in && decode_hit;
   endsequence
   sequence same_read_s;
      sfr_rd_in && decode_hit && $stable(sfr_addr_in);
   endsequence
   chk_hit_decode: assert property (sfr_hit_out == decode_hit)
      else $error("register hit flag wrong");
   chk_unmapped_read: assert property (sfr_rd_in && !decode_hit |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chk_write_read_back: assert property (reg_write_s ##1 same_read_s |=> sfr_rdata_out == ($past(sfr_wdata_in, 2) &
      ($past(sfr_addr_in) == ADDR_DCDC_CONFIG ? MASK_DCDC_CONFIG : MASK_DCDC_CONTROL)))
      else $error("read back differs from write");
   chk_rdata_hold: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
      else $error("read data moved without read");
   chk_target_table: assert property (settle_r == 2'h3 |-> target_mv_out == TARGET_MV[output_voltage_select_out])
      else $error("target does not match select");
   chk_rail_exclusive: assert property (!(rail_to_battery_out && rail_floating_out) &&
      !(converter_enable_out && (rail_to_battery_out || rail_floating_out)))
      else $error("rail connection conflict");
   chk_sleep_stops: assert property (sleep_in [*4] |=> !converter_enable_out)
      else $error("converter runs in sleep");
   chk_two_cell_off: assert property (two_cell_strap_in |-> !converter_enable_out && !switch_on_out)
      else $error("converter runs in two-cell mode");
   chk_idle_still: assert property (!converter_enable_out [*3] |-> !switch_on_out && !converter_clock_out)
      else $error("switching while disabled");
endmodule
bind dcdc_converter_control_regs dcdc_regs_checker dcdc_regs_checker_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
   .sfr_addr_in(sfr_addr_in), .sfr_page_in(sfr_page_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
   .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out),
   .two_cell_strap_in(two_cell_strap_in), .sleep_in(sleep_in), .converter_enable_out(converter_enable_out),
   .switch_on_out(switch_on_out), .output_voltage_select_out(output_voltage_select_out),
   .target_mv_out(target_mv_out), .rail_to_battery_out(rail_to_battery_out),
   .rail_floating_out(rail_floating_out), .converter_clock_out(converter_clock_out));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dcdc_pkg::*;
   localparam int mv_table [8] = '{1800, 1900, 2000, 2100, 2400, 2700, 3000, 3300};
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_page_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic sfr_rd_in = 1'b0;
   logic two_cell_strap_in = 1'b0;
   logic sleep_in = 1'b0;
   logic [7:0] sfr_rdata_out;
   logic [2:0] output_voltage_select_out;
   logic [11:0] target_mv_out;
   logic [1:0] min_pulse_width_out;
   logic sfr_hit_out, converter_enable_out, switch_on_out, small_switch_out, high_current_limit_out;
   logic rail_to_battery_out, rail_floating_out, converter_clock_out, local_osc_in, above_target_in;
   logic adc_track_window_out, adc_sar_clock_out, adc_sar_tick_out;
   int failures = 0;
   int n_tests = 0;
   always #50 clock_in = ~clock_in;
   dcdc_converter_control_regs dcdc_converter_control_regs_i (.clock_in, .arst_n_in, .sfr_addr_in, .sfr_page_in,
      .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .sfr_hit_out, .two_cell_strap_in, .sleep_in,
      .local_osc_in, .above_target_in, .converter_enable_out, .switch_on_out, .small_switch_out,
      .high_current_limit_out, .output_voltage_select_out, .target_mv_out, .min_pulse_width_out,
      .rail_to_battery_out, .rail_floating_out, .converter_clock_out, .adc_track_window_out,
      .adc_sar_clock_out, .adc_sar_tick_out);
   dcdc_far_side dcdc_far_side_i (.clock_in, .switch_on_in(switch_on_out), .adc_sar_tick_in(adc_sar_tick_out),
      .local_osc_out(local_osc_in), .above_target_out(above_target_in));
   // ------------------------------------------------------------
   // bus and compare tasks, all entered at a falling edge
   // ------------------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] page, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock_in);
      sfr_page_in = page;
      sfr_addr_in = addr;
      sfr_wdata_in = data;
      sfr_wr_in = 1'b1;
      @(negedge clock_in);
      sfr_wr_in = 1'b0;
   endtask
   // may follow a write with no gap
   task automatic rd_reg(input logic [7:0] page, input logic [7:0] addr, output logic [7:0] data);
      sfr_page_in = page;
      sfr_addr_in = addr;
      sfr_rd_in = 1'b1;
      @(negedge clock_in);
      sfr_rd_in = 1'b0;
      @(negedge clock_in);
      data = sfr_rdata_out;
   endtask
   task automatic wait_rise(output int cyc);
      cyc = 0;
      while (converter_clock_out !== 1'b0 && cyc < 40) begin
         @(negedge clock_in);
         cyc++;
      end
      while (converter_clock_out !== 1'b1 && cyc < 40) begin
         @(negedge clock_in);
         cyc++;
      end
   endtask
   task automatic do_reset(input logic strap);
      arst_n_in = 1'b0;
      two_cell_strap_in = strap;
      repeat (4) @(negedge clock_in);
      arst_n_in = 1'b1;
      repeat (4) @(negedge clock_in);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_reset();
      logic [7:0] v;
      rd_reg(8'h00, 8'h97, v);
      cmp(v, 8'h21);
      rd_reg(8'h00, 8'h96, v);
      cmp(v, 8'h00);
      cmp(small_switch_out, 1'b1);
      cmp(target_mv_out, 1900);
      cmp(converter_enable_out, 1'b1);
      $display("test reset done");
   endtask
   task automatic test_control();
      logic [7:0] d;
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         d = {i[1:0], i[0], 2'b00, i[2:0]};
         wr_reg(8'h00, 8'h97, d);
         rd_reg(8'h00, 8'h97, v);
         cmp(v, d);
         cmp(output_voltage_select_out, i);
         cmp(target_mv_out, mv_table[i]);
         cmp(min_pulse_width_out, i[1:0]);
         cmp(small_switch_out, i[0]);
      end
      wr_reg(8'h00, 8'h97, 8'h21);
      $display("test control done");
   endtask
   task automatic test_config();
      logic [7:0] v;
      wr_reg(8'h00, 8'h96, 8'h7f);
      rd_reg(8'h00, 8'h96, v);
      cmp(v, 8'h7f);
      cmp(high_current_limit_out, 1'b1);
      wr_reg(8'h00, 8'h96, 8'h00);
      wr_reg(8'h01, 8'h96, 8'h04);
      rd_reg(8'h00, 8'h96, v);
      cmp(v, 8'h00);
      cmp(high_current_limit_out, 1'b0);
      rd_reg(8'h00, 8'h95, v);
      cmp(v, 8'h00);
      $display("test config done");
   endtask
   task automatic test_clock();
      int gap;
      for (int d = 1; d < 4; d++) begin
         wr_reg(8'h00, 8'h96, 8'(d << 5) | 8'h01);
         // setting lands at a period end; the third rise is clean
         repeat (3) wait_rise(gap);
         cmp(gap, 1 << d);
      end
      wr_reg(8'h00, 8'h96, 8'h01);
      repeat (12) @(negedge clock_in);
      cmp(converter_clock_out, 1'b1);
      wr_reg(8'h00, 8'h96, 8'h09);
      repeat (4) @(negedge clock_in);
      cmp(converter_clock_out, 1'b0);
      wr_reg(8'h00, 8'h96, 8'h60);
      wait_rise(gap);
      wait_rise(gap);
      cmp(gap inside {4, 5}, 1'b1);
      $display("test clock done");
   endtask
   task automatic test_adc();
      int n;
      wr_reg(8'h00, 8'h96, 8'h31);
      repeat (16) begin
         @(negedge clock_in);
         cmp({adc_track_window_out, adc_sar_clock_out, adc_sar_tick_out}, 3'h0);
      end
      wr_reg(8'h00, 8'h97, 8'h29);
      for (int i = 0; i < 2; i++) begin
         wr_reg(8'h00, 8'h96, 8'h21 | 8'(i << 4));
         repeat (4) @(negedge clock_in);
         n = 0;
         while (adc_sar_tick_out !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
         end
         cmp(adc_sar_clock_out, i);
      end
      n = 0;
      repeat (32) begin
         @(negedge clock_in);
         n += int'(adc_track_window_out === 1'b1);
      end
      cmp(n > 0, 1'b1);
      wr_reg(8'h00, 8'h97, 8'h21);
      $display("test adc done");
   endtask
   task automatic test_sleep();
      wr_reg(8'h00, 8'h96, 8'h00);
      sleep_in = 1'b1;
      repeat (6) @(negedge clock_in);
      cmp({converter_enable_out, rail_to_battery_out, rail_floating_out}, 3'h2);
      wr_reg(8'h00, 8'h96, 8'h02);
      repeat (2) @(negedge clock_in);
      cmp({converter_enable_out, rail_to_battery_out, rail_floating_out}, 3'h1);
      sleep_in = 1'b0;
      repeat (6) @(negedge clock_in);
      cmp({converter_enable_out, rail_to_battery_out, rail_floating_out}, 3'h4);
      $display("test sleep done");
   endtask
   task automatic test_two_cell();
      logic [7:0] v;
      do_reset(1'b1);
      repeat (20) @(negedge clock_in);
      cmp({converter_enable_out, switch_on_out, converter_clock_out}, 3'h0);
      do_reset(1'b0);
      cmp(converter_enable_out, 1'b1);
      rd_reg(8'h00, 8'h97, v);
      cmp(v, 8'h21);
      $display("test two cell done");
   endtask
   task automatic print_verdict();
      $display("Counts: %0d compares, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      do_reset(1'b0);
      test_reset();
      test_control();
      test_config();
      test_clock();
      test_adc();
      test_sleep();
      test_two_cell();
      print_verdict();
   end
   // whole run is near 300 cycles
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end
endmodule
`default_nettype wire
